/* File: pkg/fieldbus_pkg.sv */
// Purpose: shared constants for the cyclic parameter/process link
// Assumes: one clock pclk at 200 MHz, active-low async reset presetn
// Notes:   both ends import this package
// Summary of operation
// - control word 0006h enables the drive
// - setpoint 1500 counts is 300 rpm
// - inputs: status, actual speed, third unused
// - process channel is 6, 12 or 20 bytes
// - eight-byte channel: mgmt, reserved, index, data MSB-first
// - whole object exchanged on every bus cycle
// - management bits 3..0 select the service
// - master sets data length field to four bytes
// - new service only on handshake bit change
// - echoed handshake bit marks service complete
// - bit seven reports service error
// - bytes two, three: index, high first
// - master drives reserved byte to zero
// - error places class, code, additional code
// - bad management or reserved: class 5 code 5
package fieldbus_pkg;
	// ****************************************************
	// process data
	// ****************************************************
	localparam logic [15:0] CTRL_ENABLE = 16'h0006;
	localparam logic [15:0] RPM_SCALE   = 16'h0005;
	localparam logic [3:0]  PD_THREE    = 4'h3;
	localparam logic [3:0]  PD_SIX      = 4'h6;
	localparam logic [3:0]  PD_TEN      = 4'hA;
	localparam logic [4:0]  BYTES_THREE = 5'h06;
	localparam logic [4:0]  BYTES_SIX   = 5'h0C;
	localparam logic [4:0]  BYTES_TEN   = 5'h14;
	// ****************************************************
	// parameter channel layout (bit 63 = byte 0 msb)
	// ****************************************************
	localparam int MGMT_HI = 63;
	localparam int MGMT_LO = 56;
	localparam int RSV_HI  = 55;
	localparam int RSV_LO  = 48;
	localparam int IDX_HI  = 47;
	localparam int IDX_LO  = 32;
	localparam int DAT_HI  = 31;
	localparam int DAT_LO  = 0;
	localparam int MB_HS   = 6;
	localparam int MB_ERR  = 7;
	localparam logic [3:0] SVC_NONE  = 4'h0;
	localparam logic [3:0] SVC_READ  = 4'h1;
	localparam logic [3:0] SVC_WRITE = 4'h2;
	localparam logic [1:0] LEN_FOUR  = 2'h3;
	localparam logic [7:0] RSV_ZERO  = 8'h00;
	localparam logic [7:0] CLS_SERVICE = 8'h05;
	localparam logic [7:0] COD_ILLEGAL = 8'h05;
	localparam logic [7:0] CLS_OTHER   = 8'h08;
	localparam logic [7:0] COD_OTHER   = 8'h00;
	localparam logic [15:0] ADD_NONE   = 16'h0000;
	localparam logic [15:0] ADD_BADIDX = 16'h0010;
	localparam int PARAM_DEPTH = 16;
	// ****************************************************
	// bus cycle timing
	// ****************************************************
	localparam int CLK_NS     = 5;
	localparam int CYCLE_NS   = 1000;
	localparam int CYCLE_CLKS = CYCLE_NS / CLK_NS;
	// ****************************************************
	// master register map and interrupt bits
	// ****************************************************
	localparam logic [7:0] A_CTRL   = 8'h00;
	localparam logic [7:0] A_SETPT  = 8'h04;
	localparam logic [7:0] A_CMD    = 8'h08;
	localparam logic [7:0] A_WDATA  = 8'h0C;
	localparam logic [7:0] A_STAT   = 8'h10;
	localparam logic [7:0] A_SPEED  = 8'h14;
	localparam logic [7:0] A_RESULT = 8'h18;
	localparam logic [7:0] A_RDATA  = 8'h1C;
	localparam logic [7:0] A_ISTAT  = 8'h20;
	localparam logic [7:0] A_ICLR   = 8'h24;
	localparam logic [7:0] A_IEN    = 8'h28;
	localparam logic [7:0] A_CONFIG = 8'h2C;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_ERR  = 1;

	// byte length of the process channel for a word count
	function automatic logic [4:0] pd_bytes(input logic [3:0] n);
		case (n)
			PD_SIX:  pd_bytes = BYTES_SIX;
			PD_TEN:  pd_bytes = BYTES_TEN;
			default: pd_bytes = BYTES_THREE;
		endcase
	endfunction
endpackage

/* File: pkg/fieldbus_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
// cyclic link between controller (master) and inverter (device)
interface fieldbus_link_if;
	logic        cyc;
	logic [3:0]  pd_count;
	logic [15:0] output_word_one;
	logic [15:0] output_word_two;
	logic [15:0] output_word_three;
	logic [63:0] par_req;
	logic        rsp_valid;
	logic [15:0] input_word_one;
	logic [15:0] input_word_two;
	logic [15:0] input_word_three;
	logic [63:0] par_rsp;

	modport master (output cyc, pd_count, output_word_one, output_word_two,
		output_word_three, par_req, input rsp_valid, input_word_one,
		input_word_two, input_word_three, par_rsp);
	modport device (input cyc, pd_count, output_word_one, output_word_two,
		output_word_three, par_req, output rsp_valid, input_word_one,
		input_word_two, input_word_three, par_rsp);
endinterface
`default_nettype wire

/* File: logic/inverter_end.sv */
// Purpose: inverter end of the cyclic process and parameter link
// Assumes: request sampled only on link.cyc, answer one clock later
// Notes:   small local parameter store stands in for the drive
`timescale 1ns/1ps
`default_nettype none
module inverter_end
	import fieldbus_pkg::*;
(
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// link
	fieldbus_link_if.device  link,
	// drive side
	input  wire logic [15:0] status_word,
	input  wire logic [15:0] actual_speed,
	output var  logic        drive_enable,
	output var  logic [15:0] control_word,
	output var  logic [15:0] setpoint_word,
	output var  logic [15:0] setpoint_rpm,
	output var  logic [4:0]  pd_length,
	output var  logic        param_exec
);
	// ****************************************************
	// state
	// ****************************************************
	logic        rsp_valid_reg;
	logic [15:0] in_one_reg;
	logic [15:0] in_two_reg;
	logic [63:0] rsp_reg;
	logic        hs_last_reg;
	logic        enable_reg;
	logic [15:0] ctrl_reg;
	logic [15:0] setp_reg;
	logic [15:0] rpm_reg;
	logic [4:0]  len_reg;
	logic        exec_reg;
	logic [31:0] param_mem [PARAM_DEPTH];

	// ****************************************************
	// request decode
	// ****************************************************
	wire logic [7:0]  mgmt    = link.par_req[MGMT_HI:MGMT_LO];
	wire logic [7:0]  rsv     = link.par_req[RSV_HI:RSV_LO];
	wire logic [15:0] index   = link.par_req[IDX_HI:IDX_LO];
	wire logic [31:0] wdata   = link.par_req[DAT_HI:DAT_LO];
	wire logic [3:0]  svc     = mgmt[3:0];
	wire logic        hs_in   = mgmt[MB_HS];
	wire logic        toggled = link.cyc && (hs_in != hs_last_reg);
	wire logic        svc_ok  = (svc == SVC_READ) || (svc == SVC_WRITE);
	wire logic        bad_code = !svc_ok || (rsv != RSV_ZERO);
	wire logic        idx_ok  = (index < 16'(PARAM_DEPTH));
	wire logic [3:0]  slot    = index[3:0];
	wire logic        do_write = toggled && !bad_code && idx_ok
		&& (svc == SVC_WRITE);

	// ****************************************************
	// response build: error words replace the data field
	// ****************************************************
	logic [31:0] rsp_data;
	logic        rsp_err;
	always_comb begin
		rsp_err  = 1'b0;
		rsp_data = wdata;
		if (bad_code) begin
			rsp_err  = 1'b1;
			rsp_data = {CLS_SERVICE, COD_ILLEGAL, ADD_NONE};
		end else if (!idx_ok) begin
			rsp_err  = 1'b1;
			rsp_data = {CLS_OTHER, COD_OTHER, ADD_BADIDX};
		end else if (svc == SVC_READ) begin
			rsp_data = param_mem[slot];
		end
	end
	// echo service, length and handshake; status bit carries the outcome
	wire logic [7:0] rsp_mgmt = {rsp_err, hs_in, mgmt[5:0]};
	wire logic [63:0] rsp_next = {rsp_mgmt, rsv, index, rsp_data};

	// ****************************************************
	// parameter store
	// ****************************************************
	// no reset on the store: software defines it by writing first
	always_ff @(posedge pclk) begin
		if (do_write) begin
			param_mem[slot] <= wdata;
		end
	end

	// ****************************************************
	// parameter handshake: act only on a change of the bit
	// ****************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hs_last_reg <= 1'b0;
			rsp_reg     <= 64'h0000000000000000;
			exec_reg    <= 1'b0;
		end else begin
			exec_reg <= toggled;
			if (toggled) begin
				hs_last_reg <= hs_in;
				rsp_reg     <= rsp_next;
			end
		end
	end

	// ****************************************************
	// process data: sampled each bus cycle
	// ****************************************************
	// divide by the scale once per cycle; the frame rate makes
	// the combinational divider cost acceptable
	wire logic [15:0] rpm_next = link.output_word_two / RPM_SCALE;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable_reg <= 1'b0;
			ctrl_reg   <= 16'h0000;
			setp_reg   <= 16'h0000;
			rpm_reg    <= 16'h0000;
			len_reg    <= BYTES_THREE;
			in_one_reg <= 16'h0000;
			in_two_reg <= 16'h0000;
		end else if (link.cyc) begin
			ctrl_reg   <= link.output_word_one;
			enable_reg <= (link.output_word_one == CTRL_ENABLE);
			setp_reg   <= link.output_word_two;
			rpm_reg    <= rpm_next;
			len_reg    <= pd_bytes(link.pd_count);
			in_one_reg <= status_word;
			in_two_reg <= actual_speed;
		end
	end

	// answer marker one clock after each bus cycle strobe
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rsp_valid_reg <= 1'b0;
		end else begin
			rsp_valid_reg <= link.cyc;
		end
	end

	// ****************************************************
	// outputs
	// ****************************************************
	assign link.rsp_valid        = rsp_valid_reg;
	assign link.input_word_one   = in_one_reg;
	assign link.input_word_two   = in_two_reg;
	assign link.input_word_three = 16'h0000;                 // no function
	assign link.par_rsp          = rsp_reg;
	assign drive_enable  = enable_reg;
	assign control_word  = ctrl_reg;
	assign setpoint_word = setp_reg;
	assign setpoint_rpm  = rpm_reg;
	assign pd_length     = len_reg;
	assign param_exec    = exec_reg;
endmodule
`default_nettype wire

/* File: logic/controller_end.sv */
// Purpose: controller end; APB registers drive the cyclic link
// Assumes: APB slave answers with pready one clock into the access
// Notes:   writing the command register starts one parameter service
//
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module controller_end
	import fieldbus_pkg::*;
(
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	output var  logic        irq,
	// link
	fieldbus_link_if.master  link
);
	logic [15:0] ctrl_reg, setp_reg, stat_reg, speed_reg;
	logic [31:0] cmd_reg, wdat_reg, rdat_reg, rdata_reg;
	logic [3:0]  cnt_reg;
	logic        hs_reg, busy_reg, err_reg, ready_reg, slverr_reg;
	logic        cyc_reg, irq_reg;
	logic [1:0]  ist_reg, ien_reg;
	logic [7:0]  tick_reg;

	// ****************************************************
	// apb decode
	// ****************************************************
	wire logic acc  = psel && penable && !ready_reg;
	wire logic wr   = acc && pwrite;
	wire logic w_cmd = wr && (paddr == A_CMD) && !busy_reg; // busy: ignored
	wire logic hit  = (paddr <= A_CONFIG) && (paddr[1:0] == 2'h0);
	wire logic done = link.rsp_valid && busy_reg
		&& (link.par_rsp[MGMT_HI-1] == hs_reg);
	wire logic derr = done && link.par_rsp[MGMT_HI];
	wire logic [1:0] ev  = {derr, done};
	wire logic [1:0] clr = (wr && paddr == A_ICLR) ? pwdata[1:0] : 2'h0;
	logic [31:0] rmux;
	always_comb begin
		case (paddr)
			A_CTRL:   rmux = {16'h0000, ctrl_reg};
			A_SETPT:  rmux = {16'h0000, setp_reg};
			A_CMD:    rmux = cmd_reg;
			A_WDATA:  rmux = wdat_reg;
			A_STAT:   rmux = {16'h0000, stat_reg};
			A_SPEED:  rmux = {16'h0000, speed_reg};
			A_RESULT: rmux = {30'h00000000, err_reg, busy_reg};
			A_RDATA:  rmux = rdat_reg;
			A_ISTAT:  rmux = {30'h00000000, ist_reg};
			A_IEN:    rmux = {30'h00000000, ien_reg};
			A_CONFIG: rmux = {28'h0000000, cnt_reg};
			default:  rmux = 32'h00000000;
		endcase
	end

	// ****************************************************
	// bus answer and software registers
	// ****************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ready_reg <= 1'b0;
			slverr_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			ctrl_reg <= 16'h0000;
			setp_reg <= 16'h0000;
			wdat_reg <= 32'h00000000;
			cnt_reg  <= PD_THREE;
			ien_reg  <= 2'h0;
		end else begin
			ready_reg  <= acc;
			slverr_reg <= acc && !hit;
			rdata_reg  <= (acc && !pwrite) ? rmux : 32'h00000000;
			if (wr && paddr == A_CTRL)   ctrl_reg <= pwdata[15:0];
			if (wr && paddr == A_SETPT)  setp_reg <= pwdata[15:0];
			if (wr && paddr == A_WDATA)  wdat_reg <= pwdata;
			if (wr && paddr == A_CONFIG) cnt_reg  <= pwdata[3:0];
			if (wr && paddr == A_IEN)    ien_reg  <= pwdata[1:0];
		end
	end

	// ****************************************************
	// service sequencing and interrupt
	// ****************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_reg <= 32'h00000000;
			hs_reg <= 1'b0;
			busy_reg <= 1'b0;
			err_reg <= 1'b0;
			rdat_reg <= 32'h00000000;
			ist_reg <= 2'h0;
			irq_reg <= 1'b0;
		end else begin
			if (w_cmd) begin
				cmd_reg  <= pwdata;
				hs_reg   <= !hs_reg;
				busy_reg <= 1'b1;
			end else if (done) begin
				busy_reg <= 1'b0;
				err_reg  <= derr;
				rdat_reg <= link.par_rsp[DAT_HI:DAT_LO];
			end
			// a new event wins over a clear in the same clock
			ist_reg <= (ist_reg & ~clr) | ev;
			irq_reg <= |(((ist_reg & ~clr) | ev) & ien_reg);
		end
	end

	// ****************************************************
	// bus cycle generator and input capture
	// ****************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_reg <= 8'h00;
			cyc_reg <= 1'b0;
			stat_reg <= 16'h0000;
			speed_reg <= 16'h0000;
		end else begin
			cyc_reg  <= (tick_reg == 8'(CYCLE_CLKS - 1));
			tick_reg <= (tick_reg == 8'(CYCLE_CLKS - 1)) ? 8'h00 : tick_reg + 8'h01;
			if (link.rsp_valid) begin
				stat_reg  <= link.input_word_one;
				speed_reg <= link.input_word_two;
			end
		end
	end

	// ****************************************************
	// outputs
	// ****************************************************
	assign prdata  = rdata_reg;
	assign pready  = ready_reg;
	assign pslverr = slverr_reg;
	assign irq     = irq_reg;
	assign link.cyc = cyc_reg;
	assign link.pd_count = cnt_reg;
	assign link.output_word_one   = ctrl_reg;
	assign link.output_word_two   = setp_reg;
	assign link.output_word_three = 16'h0000;
	// reserved forced zero, length field always four bytes
	assign link.par_req = {cmd_reg[7] & 1'b0, hs_reg, LEN_FOUR, cmd_reg[3:0],
		RSV_ZERO, cmd_reg[31:16], wdat_reg};
endmodule
`default_nettype wire

/* File: testbench/fieldbus_properties.sv */
// Purpose: link-level checks between the controller and inverter ends
// Assumes: one clock, active-low async reset
// Notes:   watches the first link only
`timescale 1ns/1ps
`default_nettype none
module fieldbus_properties
	import fieldbus_pkg::*;
(
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// link
	input wire logic        cyc,
	input wire logic [63:0] par_req,
	input wire logic        rsp_valid,
	input wire logic [15:0] input_word_one,
	input wire logic [63:0] par_rsp
);
	// ****************************************************
	// helper state
	// ****************************************************
	logic [7:0] gap_reg;
	logic       seen_reg;
	logic       hs_reg;
	logic       chg_reg;
	logic [3:0] svc_reg;

	// what the device saw at the last strobe; gap saturates so it never wraps
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap_reg  <= 8'h00;
			seen_reg <= 1'b0;
			hs_reg   <= 1'b0;
			chg_reg  <= 1'b0;
			svc_reg  <= 4'h0;
		end else begin
			gap_reg  <= cyc ? 8'h00 : ((gap_reg == 8'hFF) ? gap_reg : gap_reg + 8'h01);
			seen_reg <= seen_reg | cyc;
			chg_reg  <= cyc && (par_req[62] != hs_reg);
			hs_reg   <= cyc ? par_req[62] : hs_reg;
			svc_reg  <= cyc ? par_req[59:56] : svc_reg;
		end
	end

	// ****************************************************
	// properties
	// ****************************************************
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	rsp_after_cyc_a: assert property (cyc |=> rsp_valid)
		else $error("no response one clock after the strobe");
	rsp_cause_a: assert property (rsp_valid |-> $past(cyc))
		else $error("response without a strobe");
	cyc_period_a: assert property (cyc && seen_reg |-> gap_reg == 8'hC7)
		else $error("strobe spacing is not 200 clocks");
	reserved_zero_a: assert property (cyc |-> par_req[55:48] == RSV_ZERO)
		else $error("reserved byte not zero");
	write_len_a: assert property (cyc && par_req[59:56] == SVC_WRITE |-> par_req[61:60] == LEN_FOUR)
		else $error("write length field not four bytes");
	resp_hold_a: assert property (rsp_valid && !chg_reg |-> $stable(par_rsp))
		else $error("response changed without a handshake toggle");
	hs_echo_a: assert property (rsp_valid && chg_reg |-> par_rsp[62] == hs_reg)
		else $error("handshake bit not echoed");
	bad_svc_a: assert property (rsp_valid && chg_reg && svc_reg != SVC_READ && svc_reg != SVC_WRITE
		|-> par_rsp[63] && par_rsp[31:0] == {CLS_SERVICE, COD_ILLEGAL, ADD_NONE})
		else $error("bad service code not reported");
	words_update_a: assert property ($changed(input_word_one) |-> rsp_valid)
		else $error("input word moved outside a response");
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
// Purpose: both link ends joined, driven over APB, plus a spare faulty link
// Assumes: 200 MHz pclk, async active-low presetn
// Notes:   second inverter instance receives deliberately faulty requests
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import fieldbus_pkg::*;
;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	logic [15:0] status_word;
	logic [15:0] actual_speed;
	logic        drive_enable;
	logic [15:0] control_word;
	logic [15:0] setpoint_word;
	logic [15:0] setpoint_rpm;
	logic [4:0]  pd_length;
	logic        param_exec;
	logic [31:0] rd;
	logic        er;
	logic [15:0] cw;
	logic [15:0] sp;
	logic [15:0] idx;
	logic [31:0] d;
	logic [3:0]  pd_tab [4] = '{PD_THREE, PD_SIX, PD_TEN, 4'h9};
	int          miscompares = 0;
	int          samples_checked = 0;
	int          clk_count = 0;
	int          exec_count = 0;

	fieldbus_link_if link();
	fieldbus_link_if lnk_b();

	// ****************************************************
	// design, spare device and checker
	// ****************************************************
	controller_end u_controller_end (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq(irq), .link(link));
	inverter_end u_inverter_end (.pclk(pclk), .presetn(presetn), .link(link),
		.status_word(status_word), .actual_speed(actual_speed), .drive_enable(drive_enable),
		.control_word(control_word), .setpoint_word(setpoint_word),
		.setpoint_rpm(setpoint_rpm), .pd_length(pd_length), .param_exec(param_exec));
	inverter_end u_inverter_end_b (.pclk(pclk), .presetn(presetn), .link(lnk_b),
		.status_word(status_word), .actual_speed(actual_speed), .drive_enable(),
		.control_word(), .setpoint_word(), .setpoint_rpm(), .pd_length(), .param_exec());
	fieldbus_properties u_fieldbus_properties (.pclk(pclk), .presetn(presetn),
		.cyc(link.cyc), .par_req(link.par_req), .rsp_valid(link.rsp_valid),
		.input_word_one(link.input_word_one), .par_rsp(link.par_rsp));

	// free-running clock, 5 ns period
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	// count execute pulses; a repeated request must not add one
	always @(posedge pclk) begin
		if (param_exec === 1'b1) begin
			exec_count++;
		end
	end

	// hang guard: services take up to about 220 clocks each
	always @(posedge pclk) begin
		clk_count++;
		if (clk_count == 60000) begin
			miscompares++;
			print_verdict();
		end
	end

	// ****************************************************
	// helpers
	// ****************************************************
	function automatic logic [15:0] exp_rpm(input logic [15:0] s);
		return s / 16'h0005;
	endfunction

	function automatic logic [4:0] exp_bytes(input logic [3:0] n);
		return (n == 4'h6) ? 5'h0C : ((n == 4'hA) ? 5'h14 : 5'h06);
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR at %0t: seen %08h expected %08h", $time, seen, exp);
		end
	endtask

	// one apb transfer; caller stands just after a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wait_rsp(input int n);
		repeat (n) begin
			do @(posedge pclk); while (link.rsp_valid !== 1'b1);
		end
		@(posedge pclk);
	endtask

	// start a service, check the request on the wire, leave the read-data word in rd
	task automatic service(input logic [3:0] s, input logic [15:0] ix, input logic [31:0] v,
		input logic err);
		apb(1'b1, A_WDATA, v);
		apb(1'b1, A_CMD, {ix, 12'h000, s});
		do @(posedge pclk); while (link.cyc !== 1'b1);
		chk({12'h000, link.par_req[59:56], link.par_req[47:32]}, {12'h000, s, ix});
		if (s == SVC_WRITE) chk(link.par_req[31:0], v);
		wait_rsp(1);
		apb(1'b0, A_RESULT, 32'h0);
		chk(rd, {30'h0, err, 1'b0});
		apb(1'b0, A_RDATA, 32'h0);
	endtask

	// faulty far end on the spare link, one strobe per bus cycle
	task automatic send_b(input logic [63:0] req, input logic [1:0] top);
		lnk_b.par_req <= req;
		lnk_b.cyc <= 1'b1;
		@(posedge pclk);
		lnk_b.cyc <= 1'b0;
		repeat (CYCLE_CLKS - 1) @(posedge pclk);
		chk({lnk_b.par_rsp[63:62], lnk_b.par_rsp[29:0]}, {top, 30'h05050000});
	endtask

	task automatic print_verdict;
		if (miscompares == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// ****************************************************
	// main sequence
	// ****************************************************
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, status_word, actual_speed} = '0;
		{lnk_b.cyc, lnk_b.output_word_one, lnk_b.output_word_two} = '0;
		{lnk_b.output_word_three, lnk_b.par_req} = '0;
		lnk_b.pd_count = PD_THREE;
		void'($urandom(32'h0abe));
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		// process words: first pass is the documented corner, then random
		for (int i = 0; i < 4; i++) begin
			cw = (i == 0) ? CTRL_ENABLE : 16'($urandom);
			sp = (i == 0) ? 16'h05DC : 16'($urandom);
			status_word <= 16'($urandom);
			actual_speed <= 16'($urandom);
			apb(1'b1, A_CTRL, {16'h0, cw});
			apb(1'b1, A_SETPT, {16'h0, sp});
			wait_rsp(2);
			chk({31'h0, drive_enable}, {31'h0, cw == CTRL_ENABLE});
			chk({16'h0, control_word}, {16'h0, cw});
			chk({16'h0, setpoint_word}, {16'h0, sp});
			chk({16'h0, setpoint_rpm}, {16'h0, exp_rpm(sp)});
			apb(1'b0, A_STAT, 32'h0);
			chk(rd, {16'h0, status_word});
			apb(1'b0, A_SPEED, 32'h0);
			chk(rd, {16'h0, actual_speed});
		end
		// every word count, plus an unsupported one
		foreach (pd_tab[k]) begin
			apb(1'b1, A_CONFIG, {28'h0, pd_tab[k]});
			wait_rsp(2);
			chk({27'h0, pd_length}, {27'h0, exp_bytes(pd_tab[k])});
		end
		// enabled interrupt, then clear
		apb(1'b1, A_IEN, 32'h3);
		for (int i = 0; i < 3; i++) begin
			idx = 16'($urandom_range(15));
			d = $urandom;
			service(SVC_WRITE, idx, d, 1'b0);
			chk({31'h0, irq}, 32'h1);
			service(SVC_READ, idx, 32'h0, 1'b0);
			chk(rd, d);
			apb(1'b1, A_ICLR, 32'h3);
			@(posedge pclk);
			chk({31'h0, irq}, 32'h0);
		end
		service(4'h3, 16'h0001, 32'h0, 1'b1);
		chk(rd, 32'h05050000);
		service(SVC_READ, 16'h0010, 32'h0, 1'b1);
		chk(rd, 32'h08000010);
		apb(1'b0, A_ISTAT, 32'h0);
		chk(rd, 32'h3);
		// masked interrupt still sets status
		apb(1'b1, A_IEN, 32'h0);
		apb(1'b1, A_ICLR, 32'h3);
		service(SVC_READ, 16'h0002, 32'h0, 1'b0);
		chk({31'h0, irq}, 32'h0);
		apb(1'b0, A_ISTAT, 32'h0);
		chk(rd, 32'h1);
		apb(1'b0, 8'h30, 32'h0);
		chk({er, rd[30:0]}, 32'h80000000);
		// spare link: bad reserved byte, repeat without toggle, bad code
		send_b({8'h41, 8'h01, 16'h0002, 32'h0}, 2'b11);
		send_b({8'h41, 8'h00, 16'h0002, 32'h0}, 2'b11);
		send_b({8'h0F, 8'h00, 16'h0002, 32'h0}, 2'b10);
		// nine services were started on the main link, each toggled once
		chk(32'(exec_count), 32'h00000009);
		print_verdict();
	end
endmodule
`default_nettype wire
